// [rtl/pms_consts.svh]
// Summary of operation
// - Two software-entered low-power modes, light sleep and deep stop; execution ceases in both.
// - Writing 01 hex to power control register 87 hex enters light sleep.
// - Light sleep halts only the CPU; oscillator, peripherals, brown-out detector keep running.
// - Light sleep ends on any reset or interrupt; a reset reinitialises all logic (here the reset flags and configuration register are kept).
// - Writing 03 hex to the power control register enters deep stop.
// - Deep stop halts oscillator and blocks, regulator stops, brown-out detector disabled.
// - Deep stop preserves all register and RAM contents.
// - Deep stop ends on reset or pin interrupt; reset keeps brown-out flag register.
// - Only power-on, pin and brown-out resets release deep stop; no watchdog reset there.
// - Wake from deep stop holds system clock off for the interval timer period.
// - Key, external interrupt, serial receive low or pin-change wake deep stop.
// - A wake in deep stop first enables brown-out detector and checks supply.
// - Supply above stop level at the check wakes normally and resumes execution.
// - Supply low stays in deep stop; later good wake issues a brown-out reset.
// - A supply drop enters brown-out mode, like deep stop with detector still on.
// - Brown-out mode keeps ports or makes them pulled-up inputs; CPU always suspended.
// - After a successful exit from sleep or stop the power control register clears.
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// register indices, byte address is four times the index
`define PMS_IDX_BOR_FLAGS 8'h86
`define PMS_IDX_PWR_CTRL 8'h87
`define PMS_IDX_STATUS 8'h88
`define PMS_IDX_CFG 8'h89

// reset values and mode codes
`define PMS_PWR_CTRL_RST 8'h00
`define PMS_MODE_SLEEP 8'h01
`define PMS_MODE_STOP 8'h03
`define PMS_CFG_RST 4'h7
`define PMS_FLAGS_RST 4'h1

// field positions
`define PMS_CFG_SEL_MSB 2
`define PMS_CFG_PULLUP_BIT 3
`define PMS_CAUSE_POR 0
`define PMS_CAUSE_EXT 1
`define PMS_CAUSE_BOR 2
`define PMS_CAUSE_WDT 3

// timing, clock at 10 MHz
`define PMS_CLK_MHZ 10
`define PMS_EXT_RST_NS 8000
`define PMS_EXT_RST_CYC ((`PMS_EXT_RST_NS * `PMS_CLK_MHZ + 999) / 1000)
`define PMS_BOD_FILT_NS 2000
`define PMS_BOD_FILT_CYC ((`PMS_BOD_FILT_NS * `PMS_CLK_MHZ + 999) / 1000)
`define PMS_BOD_SETTLE_CYC (`PMS_BOD_FILT_CYC + 4)
`define PMS_RST_PULSE_CYC 5
`define PMS_STAB_UNIT_CYC 256

`endif

// [rtl/pms_pkg.sv]
package pms_pkg;
	// one-hot sequencer states
	typedef enum logic [6:0] {
		PMS_RUN = 7'b0000001,
		PMS_SLEEP = 7'b0000010,
		PMS_STOP = 7'b0000100,
		PMS_BODCHK = 7'b0001000,
		PMS_STAB = 7'b0010000,
		PMS_BROWNOUT = 7'b0100000,
		PMS_RSTOUT = 7'b1000000
	} pms_state_t;

	typedef logic [3:0] pms_cause_t;
endpackage

// [rtl/pms_tmr_if.sv]
`timescale 1ns/1ns
`default_nettype none
// start and done of the stability wait
interface pms_tmr_if;
	logic start;
	logic [2:0] sel;
	logic busy;
	logic done;
	modport ctrl(output start, output sel, input busy, input done);
	modport timer(input start, input sel, output busy, output done);
endinterface
`default_nettype wire

// [rtl/pms_glitch_filter.sv]
`timescale 1ns/1ns
`default_nettype none
// synchronises a pin and passes its active level only after it holds steady
module pms_glitch_filter #(
	parameter int CYCLES = 20
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic pin_async,
	output logic level
);
	logic sync1_ff;
	logic sync2_ff;
	logic [15:0] cnt_ff;

	// two flops before anything looks at the pin
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= pin_async;
			sync2_ff <= sync1_ff;
		end
	end

	// count steady active cycles, release drops at once
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_ff <= 16'h0000;
			level <= 1'b0;
		end else if (!sync2_ff) begin
			cnt_ff <= 16'h0000;
			level <= 1'b0;
		end else if (cnt_ff >= 16'(CYCLES - 1)) begin
			level <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// [rtl/pms_stab_timer.sv]
`timescale 1ns/1ns
`default_nettype none
// interval timer overflow: unit cycles shifted by the programmed select
module pms_stab_timer #(
	parameter int UNIT = 256
) (
	input wire logic clk,
	input wire logic reset,
	pms_tmr_if.timer tmr
);
	logic [31:0] cnt_ff;
	logic busy_ff;

	assign tmr.busy = busy_ff;

	// load on start, count down, single done pulse at zero
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_ff <= 32'h00000000;
			busy_ff <= 1'b0;
			tmr.done <= 1'b0;
		end else if (tmr.start) begin
			cnt_ff <= (32'(UNIT) << tmr.sel) - 32'h00000001;
			busy_ff <= 1'b1;
			tmr.done <= 1'b0;
		end else if (busy_ff && cnt_ff == 32'h00000000) begin
			busy_ff <= 1'b0;
			tmr.done <= 1'b1;
		end else begin
			cnt_ff <= busy_ff ? cnt_ff - 32'h00000001 : cnt_ff;
			tmr.done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [rtl/pms_power_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pms_consts.svh"
// power mode sequencer with an ahb-lite register slave
module pms_power_sequencer #(
	parameter int STAB_UNIT = `PMS_STAB_UNIT_CYC,
	parameter int EXT_RST_CYCLES = `PMS_EXT_RST_CYC,
	parameter int BOD_FILT_CYCLES = `PMS_BOD_FILT_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic power_on_reset_n,
	input wire logic external_reset_pin_n,
	input wire logic brownout_low,
	input wire logic [3:0] wake_pins,
	input wire logic irq_req,
	input wire logic wdt_reset_req,
	output logic cpu_halt,
	output logic osc_enable,
	output logic periph_clk_enable,
	output logic sys_clk_enable,
	output logic regulator_stop,
	output logic brownout_detector_enable,
	output logic port_pullup_mode,
	output logic chip_reset
);
	pms_tmr_if tmr();

	pms_pkg::pms_state_t state_ff;
	pms_pkg::pms_state_t nxt_state;
	pms_pkg::pms_cause_t cause_ff;
	pms_pkg::pms_cause_t nxt_cause;
	logic [7:0] power_mode_control_ff;
	logic [3:0] cfg_ff;
	logic [3:0] flags_ff;
	logic [7:0] cnt_ff;
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic ext_rst;
	logic bod_low;
	logic por;
	logic wake_any;
	logic ap_valid_ff;
	logic ap_write_ff;
	logic [31:0] ap_addr_ff;
	logic [31:0] hrdata_ff;
	logic wr_pwr;
	logic wr_cfg;
	logic wr_flags;
	logic ap_take;
	logic cnt_clr;
	logic exit_ok;

	// byte address of a register index
	function automatic logic hit(input logic [31:0] addr, input logic [7:0] idx);
		hit = addr == {22'h000000, idx, 2'b00};
	endfunction

	// the bus never stalls and never fails
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	// filtered reset pin and brown-out level
	pms_glitch_filter #(
		.CYCLES(EXT_RST_CYCLES)
	) u_ext_filter (
		.clk(clk),
		.reset(reset),
		.pin_async(~external_reset_pin_n),
		.level(ext_rst)
	);

	pms_glitch_filter #(
		.CYCLES(BOD_FILT_CYCLES)
	) u_bod_filter (
		.clk(clk),
		.reset(reset),
		.pin_async(brownout_low),
		.level(bod_low)
	);

	pms_stab_timer #(
		.UNIT(STAB_UNIT)
	) u_stab_timer (
		.clk(clk),
		.reset(reset),
		.tmr(tmr.timer)
	);

	// two-flop synchronisers for power-on reset and the wake pins
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_ff <= 5'h00;
			sync2_ff <= 5'h00;
		end else begin
			sync1_ff <= {~power_on_reset_n, wake_pins};
			sync2_ff <= sync1_ff;
		end
	end

	assign por = sync2_ff[4];
	assign wake_any = |sync2_ff[3:0];

	// address phase capture
	assign ap_take = hsel && hready && htrans[1];

	always_ff @(posedge clk) begin
		if (reset) begin
			ap_valid_ff <= 1'b0;
			ap_write_ff <= 1'b0;
			ap_addr_ff <= 32'h00000000;
		end else if (hready) begin
			ap_valid_ff <= ap_take;
			ap_write_ff <= hwrite;
			ap_addr_ff <= haddr;
		end
	end

	// data phase write strobes
	assign wr_pwr = ap_valid_ff && ap_write_ff && hit(ap_addr_ff, `PMS_IDX_PWR_CTRL);
	assign wr_cfg = ap_valid_ff && ap_write_ff && hit(ap_addr_ff, `PMS_IDX_CFG);
	assign wr_flags = ap_valid_ff && ap_write_ff && hit(ap_addr_ff, `PMS_IDX_BOR_FLAGS);

	// read data registered from the address phase, unmapped reads zero
	always_ff @(posedge clk) begin
		if (reset) begin
			hrdata_ff <= 32'h00000000;
		end else if (ap_take && !hwrite) begin
			if (hit(haddr, `PMS_IDX_PWR_CTRL)) begin
				hrdata_ff <= {24'h000000, power_mode_control_ff};
			end else if (hit(haddr, `PMS_IDX_BOR_FLAGS)) begin
				hrdata_ff <= {28'h0000000, flags_ff};
			end else if (hit(haddr, `PMS_IDX_STATUS)) begin
				hrdata_ff <= {20'h00000, cause_ff, 1'b0, state_ff};
			end else if (hit(haddr, `PMS_IDX_CFG)) begin
				hrdata_ff <= {28'h0000000, cfg_ff};
			end else begin
				hrdata_ff <= 32'h00000000;
			end
		end
	end

	// power control register: stored as written, cleared on a good exit
	assign exit_ok = (state_ff == pms_pkg::PMS_SLEEP && nxt_state == pms_pkg::PMS_RUN) ||
		(state_ff == pms_pkg::PMS_STAB && nxt_state == pms_pkg::PMS_RUN);

	always_ff @(posedge clk) begin
		if (reset) begin
			power_mode_control_ff <= `PMS_PWR_CTRL_RST;
		end else if (wr_pwr) begin
			power_mode_control_ff <= hwdata[7:0];
		end else if (exit_ok || state_ff == pms_pkg::PMS_RSTOUT) begin
			power_mode_control_ff <= `PMS_PWR_CTRL_RST;
		end
	end

	// stability select and brown-out port behaviour
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_ff <= `PMS_CFG_RST;
		end else if (wr_cfg) begin
			cfg_ff <= hwdata[3:0];
		end
	end

	// reset cause flags survive the reset this block issues; set beats clear
	always_ff @(posedge clk) begin
		if (reset) begin
			flags_ff <= `PMS_FLAGS_RST;
		end else begin
			flags_ff <= (flags_ff & ~(wr_flags ? hwdata[3:0] : 4'h0)) |
				((state_ff == pms_pkg::PMS_RSTOUT) ? cause_ff : 4'h0);
		end
	end

	// next state of the sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cause = cause_ff;
		case (state_ff)
			pms_pkg::PMS_RUN: begin
				if (por || ext_rst || wdt_reset_req) begin
					nxt_cause = {wdt_reset_req, 1'b0, ext_rst, por};
					nxt_state = pms_pkg::PMS_RSTOUT;
				end else if (bod_low) begin
					nxt_state = pms_pkg::PMS_BROWNOUT;
				end else if (wr_pwr && hwdata[7:0] == `PMS_MODE_SLEEP) begin
					nxt_state = pms_pkg::PMS_SLEEP;
				end else if (wr_pwr && hwdata[7:0] == `PMS_MODE_STOP) begin
					nxt_state = pms_pkg::PMS_STOP;
				end
			end
			pms_pkg::PMS_SLEEP: begin
				if (por || ext_rst || wdt_reset_req) begin
					nxt_cause = {wdt_reset_req, 1'b0, ext_rst, por};
					nxt_state = pms_pkg::PMS_RSTOUT;
				end else if (bod_low) begin
					nxt_state = pms_pkg::PMS_BROWNOUT;
				end else if (irq_req) begin
					nxt_state = pms_pkg::PMS_RUN;
				end
			end
			pms_pkg::PMS_STOP: begin
				// watchdog request ignored: its clock is halted here
				if (por || ext_rst) begin
					nxt_cause = cause_ff | {2'b00, ext_rst, por};
					nxt_state = pms_pkg::PMS_STAB;
				end else if (wake_any) begin
					nxt_state = pms_pkg::PMS_BODCHK;
				end
			end
			pms_pkg::PMS_BODCHK: begin
				if (por || ext_rst) begin
					nxt_cause = cause_ff | {2'b00, ext_rst, por};
					nxt_state = pms_pkg::PMS_STAB;
				end else if (cnt_ff >= 8'(`PMS_BOD_SETTLE_CYC - 1)) begin
					if (bod_low) begin
						nxt_cause = cause_ff | 4'h4;
						nxt_state = pms_pkg::PMS_STOP;
					end else begin
						nxt_state = pms_pkg::PMS_STAB;
					end
				end
			end
			pms_pkg::PMS_STAB: begin
				if (por || ext_rst) begin
					nxt_cause = cause_ff | {2'b00, ext_rst, por};
				end
				if (tmr.done) begin
					nxt_state = (|nxt_cause) ? pms_pkg::PMS_RSTOUT : pms_pkg::PMS_RUN;
				end
			end
			pms_pkg::PMS_BROWNOUT: begin
				if (!bod_low) begin
					nxt_cause = cause_ff | 4'h4;
					nxt_state = pms_pkg::PMS_STAB;
				end
			end
			pms_pkg::PMS_RSTOUT: begin
				if (cnt_ff >= 8'(`PMS_RST_PULSE_CYC - 1) && !por && !ext_rst) begin
					nxt_cause = 4'h0;
					nxt_state = pms_pkg::PMS_RUN;
				end
			end
			default: begin
				nxt_state = pms_pkg::PMS_RUN;
			end
		endcase
	end

	// state and cause registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= pms_pkg::PMS_RUN;
			cause_ff <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			cause_ff <= nxt_cause;
		end
	end

	// cycle counter for detector settling and the reset pulse
	assign cnt_clr = nxt_state != state_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_ff <= 8'h00;
		end else if (cnt_clr) begin
			cnt_ff <= 8'h00;
		end else if (cnt_ff != 8'hff) begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	// stability wait started on each entry into the wait state
	assign tmr.start = nxt_state == pms_pkg::PMS_STAB && state_ff != pms_pkg::PMS_STAB;
	assign tmr.sel = cfg_ff[`PMS_CFG_SEL_MSB:0];

	// clock, regulator and detector controls decoded from the state register
	assign cpu_halt = state_ff != pms_pkg::PMS_RUN;
	assign periph_clk_enable = state_ff == pms_pkg::PMS_RUN ||
		state_ff == pms_pkg::PMS_SLEEP;
	assign osc_enable = state_ff != pms_pkg::PMS_STOP &&
		state_ff != pms_pkg::PMS_BROWNOUT;
	assign sys_clk_enable = state_ff == pms_pkg::PMS_RUN ||
		state_ff == pms_pkg::PMS_SLEEP || state_ff == pms_pkg::PMS_RSTOUT;
	assign regulator_stop = state_ff == pms_pkg::PMS_STOP ||
		state_ff == pms_pkg::PMS_BROWNOUT;
	assign brownout_detector_enable = state_ff != pms_pkg::PMS_STOP;
	assign port_pullup_mode = state_ff == pms_pkg::PMS_BROWNOUT &&
		cfg_ff[`PMS_CFG_PULLUP_BIT];
	assign chip_reset = state_ff == pms_pkg::PMS_RSTOUT;
	// registers hold in stop except cnt_ff, which clears on stop entry and counts up to ff, and the synchronisers, which keep sampling the pins
endmodule
`default_nettype wire

// [tb/pms_power_sequencer_properties.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pms_consts.svh"
// ties mode outputs to power control writes, wake inputs and resets
module pms_power_sequencer_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic irq_req,
	input wire logic wdt_reset_req,
	input wire logic power_on_reset_n,
	input wire logic external_reset_pin_n,
	input wire logic cpu_halt,
	input wire logic osc_enable,
	input wire logic periph_clk_enable,
	input wire logic sys_clk_enable,
	input wire logic regulator_stop,
	input wire logic brownout_detector_enable,
	input wire logic port_pullup_mode,
	input wire logic chip_reset
);
	localparam logic [31:0] A_PWR = {22'h0, `PMS_IDX_PWR_CTRL, 2'b00};
	logic wr_ff;
	logic quiet;
	logic run_wr;
	// power control write in its data phase
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ff <= 1'b0;
		end else begin
			wr_ff <= hsel && hready && htrans[1] && hwrite && haddr == A_PWR;
		end
	end
	// no reset source competes with the write
	assign quiet = power_on_reset_n && external_reset_pin_n && !chip_reset && !wdt_reset_req;
	assign run_wr = wr_ff && quiet && !cpu_halt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_sleep_entry: assert property (run_wr && hwdata[7:0] == `PMS_MODE_SLEEP |=>
		cpu_halt && osc_enable && periph_clk_enable && brownout_detector_enable)
		else $error("light sleep not entered");
	a_stop_entry: assert property (run_wr && hwdata[7:0] == `PMS_MODE_STOP |=>
		cpu_halt && regulator_stop && !osc_enable && !periph_clk_enable
		&& !brownout_detector_enable)
		else $error("deep stop not entered");
	a_other_code: assert property (run_wr && hwdata[7:0] != `PMS_MODE_SLEEP
		&& hwdata[7:0] != `PMS_MODE_STOP |=> !cpu_halt)
		else $error("mode entered on other code");
	a_run_clocks: assert property (!cpu_halt |-> osc_enable && periph_clk_enable
		&& sys_clk_enable && !regulator_stop)
		else $error("running with clocks off");
	a_sleep_wake: assert property (cpu_halt && periph_clk_enable && irq_req && quiet
		|-> ##[1:2] !cpu_halt)
		else $error("no wake from light sleep");
	a_stop_no_wdt: assert property (regulator_stop && !brownout_detector_enable
		&& wdt_reset_req |=> !chip_reset)
		else $error("watchdog reset in deep stop");
	a_wake_check: assert property (regulator_stop && !brownout_detector_enable
		##1 !regulator_stop |-> (brownout_detector_enable && osc_enable && !sys_clk_enable)[*8])
		else $error("wake check sequence wrong");
	a_brownout_mode: assert property (regulator_stop && brownout_detector_enable |->
		cpu_halt && !osc_enable && !sys_clk_enable)
		else $error("brownout mode outputs wrong");
	a_pullup_only: assert property (port_pullup_mode |->
		regulator_stop && brownout_detector_enable)
		else $error("pull-up outside brownout mode");
	a_reset_pulse: assert property ($rose(chip_reset) |-> chip_reset[*5])
		else $error("chip reset pulse too short");
endmodule
bind pms_power_sequencer pms_power_sequencer_chk u_pms_power_sequencer_chk (
	.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .irq_req(irq_req),
	.wdt_reset_req(wdt_reset_req), .power_on_reset_n(power_on_reset_n),
	.external_reset_pin_n(external_reset_pin_n), .cpu_halt(cpu_halt),
	.osc_enable(osc_enable), .periph_clk_enable(periph_clk_enable),
	.sys_clk_enable(sys_clk_enable), .regulator_stop(regulator_stop),
	.brownout_detector_enable(brownout_detector_enable),
	.port_pullup_mode(port_pullup_mode), .chip_reset(chip_reset)
);
`default_nettype wire

// [tb/test_power_mode_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pms_consts.svh"
`define CHK(n, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("MISMATCH %s expected %h seen %h", n, e, g); \
	end \
end
`define WAIT_FOR(c) begin \
	n_w = 0; \
	while (!(c) && n_w < 1000) begin \
		@(posedge clk); \
		#1; \
		n_w++; \
	end \
	`CHK("wait", 1'b1, (c)) \
end
module test_power_mode_sequencer;
	typedef struct packed {
		logic wr;
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} pms_row_t;
	localparam logic [31:0] A_FLG = {22'h0, `PMS_IDX_BOR_FLAGS, 2'b00};
	localparam logic [31:0] A_PWR = {22'h0, `PMS_IDX_PWR_CTRL, 2'b00};
	localparam logic [31:0] A_STS = {22'h0, `PMS_IDX_STATUS, 2'b00};
	localparam logic [31:0] A_CFG = {22'h0, `PMS_IDX_CFG, 2'b00};
	logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, irq_req, wdt_reset_req;
	logic power_on_reset_n, external_reset_pin_n, brownout_low, chip_reset;
	logic cpu_halt, osc_enable, periph_clk_enable, sys_clk_enable, regulator_stop;
	logic brownout_detector_enable, port_pullup_mode;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] wake_pins;
	logic [5:0] outs;
	int n_errors = 0;
	int total_checks = 0;
	int n_w;
	// reset values, stored codes without mode entry, unmapped place
	pms_row_t rows [7] = '{
		'{1'b0, A_FLG, 32'h0, {28'h0, `PMS_FLAGS_RST}},
		'{1'b0, A_PWR, 32'h0, 32'h0},
		'{1'b0, A_STS, 32'h0, {25'h0, pms_pkg::PMS_RUN}},
		'{1'b1, A_PWR, 32'h55, 32'h55},
		'{1'b1, A_PWR, 32'h02, 32'h02},
		'{1'b1, A_CFG, 32'h8, 32'h8},
		'{1'b1, 32'h0, 32'hff, 32'h0}
	};
	assign hready = hreadyout;
	assign outs = {cpu_halt, osc_enable, periph_clk_enable, sys_clk_enable, regulator_stop,
		brownout_detector_enable};
	pms_power_sequencer #(.STAB_UNIT(4), .EXT_RST_CYCLES(4), .BOD_FILT_CYCLES(2))
	u_pms_power_sequencer (
		.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.power_on_reset_n(power_on_reset_n), .external_reset_pin_n(external_reset_pin_n),
		.brownout_low(brownout_low), .wake_pins(wake_pins), .irq_req(irq_req),
		.wdt_reset_req(wdt_reset_req), .cpu_halt(cpu_halt), .osc_enable(osc_enable),
		.periph_clk_enable(periph_clk_enable), .sys_clk_enable(sys_clk_enable),
		.regulator_stop(regulator_stop), .brownout_detector_enable(brownout_detector_enable),
		.port_pullup_mode(port_pullup_mode), .chip_reset(chip_reset)
	);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		#1;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task test_done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// cut a hung run short
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		test_done();
	end
	initial begin
		{reset, power_on_reset_n, external_reset_pin_n} = 3'b111;
		{hsel, hwrite, irq_req, wdt_reset_req, brownout_low} = 5'h0;
		{haddr, hwdata, htrans, wake_pins} = '0;
		hsize = 3'b010;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		tick(3);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				ahb(1'b1, rows[i].a, rows[i].d);
			end
			ahb(1'b0, rows[i].a, 32'h0);
			`CHK("row_rd", rows[i].e, q)
			`CHK("row_halt", 1'b0, cpu_halt)
			`CHK("row_resp", 2'b01, {hresp, hreadyout})
		end
		// light sleep, left by an interrupt
		ahb(1'b1, A_PWR, {24'h0, `PMS_MODE_SLEEP});
		`CHK("sleep", 6'b111101, outs)
		@(posedge clk) irq_req <= 1'b1;
		`WAIT_FOR(!cpu_halt)
		@(posedge clk) irq_req <= 1'b0;
		ahb(1'b0, A_PWR, 32'h0);
		`CHK("sleep_clr", 32'h0, q)
		// deep stop, woken by each wake source, watchdog ignored
		for (int k = 0; k < 4; k++) begin
			ahb(1'b1, A_PWR, {24'h0, `PMS_MODE_STOP});
			`CHK("stop", 6'b100010, outs)
			@(posedge clk) wdt_reset_req <= 1'b1;
			tick(6);
			`CHK("wdt", 1'b0, chip_reset)
			@(posedge clk) wdt_reset_req <= 1'b0;
			@(posedge clk) wake_pins[k] <= 1'b1;
			tick(5);
			`CHK("bodchk", 6'b110001, outs)
			@(posedge clk) wake_pins <= 4'h0;
			`WAIT_FOR(!cpu_halt)
			ahb(1'b0, A_PWR, 32'h0);
			`CHK("stop_clr", 32'h0, q)
		end
		// configuration survives the stop visits
		ahb(1'b0, A_CFG, 32'h0);
		`CHK("stop_keep", 32'h8, q)
		// low supply at the wake check keeps deep stop, next wake resets
		ahb(1'b1, A_PWR, {24'h0, `PMS_MODE_STOP});
		@(posedge clk) brownout_low <= 1'b1;
		tick(10);
		`CHK("bod_off", 6'b100010, outs)
		@(posedge clk) wake_pins <= 4'h2;
		tick(5);
		@(posedge clk) wake_pins <= 4'h0;
		tick(40);
		`CHK("low_stay", 6'b100010, outs)
		@(posedge clk) brownout_low <= 1'b0;
		tick(10);
		@(posedge clk) wake_pins <= 4'h4;
		`WAIT_FOR(chip_reset)
		@(posedge clk) wake_pins <= 4'h0;
		`WAIT_FOR(!chip_reset && !cpu_halt)
		ahb(1'b0, A_FLG, 32'h0);
		`CHK("bor_flag", 1'b1, q[`PMS_CAUSE_BOR])
		ahb(1'b1, A_FLG, 32'hf);
		ahb(1'b0, A_FLG, 32'h0);
		`CHK("flag_w1c", 32'h0, q)
		// supply drop while running
		ahb(1'b1, A_CFG, 32'h8);
		@(posedge clk) brownout_low <= 1'b1;
		`WAIT_FOR(port_pullup_mode)
		`CHK("bo_mode", 6'b100011, outs)
		@(posedge clk) brownout_low <= 1'b0;
		`WAIT_FOR(chip_reset)
		`WAIT_FOR(!chip_reset && !cpu_halt)
		ahb(1'b0, A_FLG, 32'h0);
		`CHK("bo_flag", 1'b1, q[`PMS_CAUSE_BOR])
		// pin reset ends light sleep
		ahb(1'b1, A_PWR, {24'h0, `PMS_MODE_SLEEP});
		@(posedge clk) external_reset_pin_n <= 1'b0;
		`WAIT_FOR(chip_reset)
		@(posedge clk) external_reset_pin_n <= 1'b1;
		`WAIT_FOR(!chip_reset && !cpu_halt)
		ahb(1'b0, A_PWR, 32'h0);
		`CHK("ext_clr", 32'h0, q)
		ahb(1'b0, A_FLG, 32'h0);
		`CHK("ext_flag", 1'b1, q[`PMS_CAUSE_EXT])
		// block reset in mid-run while in light sleep
		ahb(1'b1, A_PWR, {24'h0, `PMS_MODE_SLEEP});
		@(posedge clk) reset <= 1'b1;
		tick(3);
		@(posedge clk) reset <= 1'b0;
		tick(1);
		`CHK("rst_outs", 6'b011101, outs)
		ahb(1'b0, A_PWR, 32'h0);
		`CHK("rst_pwr", 32'h0, q)
		ahb(1'b0, A_FLG, 32'h0);
		`CHK("rst_flags", {28'h0, `PMS_FLAGS_RST}, q)
		test_done();
	end
endmodule
`default_nettype wire
